// ---- rtl/bsc_controller.sv ----
// Control logic of a high-voltage buck switch: supply lockout, on/off pulse
// control, soft start, blanking and protection. Assumes analogue comparators
// outside drive the inputs and that the gate and regulator pins act on levels.
//
// How it works
// R1: Supply at start level: begin running and turn the charging regulator off.
// R2: Supply below lower hysteresis level: turn the charging regulator back on.
// R3: Supply below minimum operating level: stop; regulator then recharges the rail.
// R4: While running, feedback below reference turns the switch on.
// R5: Switch turns off once sensed current reaches the present peak limit.
// R6: Peak limit is maximum minus 1 mA per microsecond of excess off time.
// R7: Switch stays off at least the minimum off time before the next turn-on.
// R8: Start-up uses two decreasing minimum off times, 128 switchings each, then the normal one.
// R9: Soft start ends early once the output reaches its desired level.
// R10: Rising load lowers the feedback reference; faster changes take bigger steps.
// R11: For the blanking time after turn-on, current limit is ignored, gate stays on.
// R12: Current above short-circuit level shuts down; resume once it is gone.
// R13: Overload trips only after feedback stays below its level for the delay.
// R14: Feedback below open-loop level stops switching and starts a restart cycle.
// R15: Open-loop detection is ignored for the first 64 start-up switchings.
// R16: Over-temperature stops switching until the cooled indication appears.
// R17: In thermal shutdown let the rail sag to restart level, then recharge.
// R18: Comparator inputs are synchronised; any protection state forces the gate low.
`timescale 1ns/1ns
`include "bsc_params.svh"
module bsc_controller
    import bsc_pkg::*;
#(
    parameter int SOFT_LONG_CYCLES = `BSC_SOFT_LONG_CYCLES,
    parameter int OVERLOAD_CYCLES  = `BSC_OVERLOAD_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       vcc_above_start,
    input  wire logic       vcc_above_hyst,
    input  wire logic       vcc_above_uvlo,
    input  wire logic       vcc_above_restart,
    input  wire logic       fb_below_ref,
    input  wire logic       fb_below_overload,
    input  wire logic       fb_below_open_loop,
    input  wire logic       current_at_limit,
    input  wire logic       current_above_short,
    input  wire logic       temp_above_trip,
    input  wire logic       temp_cooled,
    output logic            gate_drive,
    output logic            hv_regulator_enable,
    output logic [7:0]      peak_limit_ma,
    output logic [3:0]      error_amplifier_compensation,
    output logic            running,
    output logic            short_circuit_protection,
    output logic            overload_protection,
    output logic            open_loop_protection,
    output logic            thermal_shutdown
);
    localparam int MINOFF_W   = 16;
    localparam int OVERLOAD_W = 28;
    localparam int LEB_W      = 8;

    // ********************************************************************
    // Parameter checks
    // ********************************************************************
    if (SOFT_LONG_CYCLES < 1 || SOFT_LONG_CYCLES >= (1 << MINOFF_W)) begin : g_bad_soft
        $error("SOFT_LONG_CYCLES out of range");
    end
    if (OVERLOAD_CYCLES < 1 || OVERLOAD_CYCLES >= (1 << OVERLOAD_W)) begin : g_bad_ovl
        $error("OVERLOAD_CYCLES out of range");
    end

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        bsc_comp_type  sync1;
        bsc_comp_type  sync2;
        bsc_state_type state;
        logic          gate;
        logic          hv;
        bsc_stage_type stage;
        logic [6:0]    switch_count;
        logic [6:0]    prescale;
        logic [7:0]    off_us;
        logic [7:0]    last_off_us;
        logic [7:0]    peak_limit;
        logic [3:0]    trim;
        logic          overload_trip;
        logic          open_loop_trip;
    } bsc_ctrl_state_type;

    localparam bsc_ctrl_state_type RESET_STATE = '{
        sync1: '0, sync2: '0, state: BSC_CHARGE, gate: 1'b0, hv: 1'b1,
        stage: BSC_STAGE_LONG, switch_count: '0, prescale: '0, off_us: '0,
        last_off_us: '0, peak_limit: `BSC_PEAK_MAX_MA, trim: '0,
        overload_trip: 1'b0, open_loop_trip: 1'b0};

    bsc_ctrl_state_type state_reg;
    bsc_ctrl_state_type state_next;
    bsc_comp_type       comp_in;
    bsc_comp_type       s;

    bsc_timer_if #(.WIDTH(LEB_W))      leb_if ();
    bsc_timer_if #(.WIDTH(MINOFF_W))   minoff_if ();
    bsc_timer_if #(.WIDTH(OVERLOAD_W)) overload_if ();

    bsc_timer #(.WIDTH(LEB_W)) u_leb_timer (
        .clock (clock),
        .rst   (rst),
        .port  (leb_if.timer)
    );
    bsc_timer #(.WIDTH(MINOFF_W)) u_minoff_timer (
        .clock (clock),
        .rst   (rst),
        .port  (minoff_if.timer)
    );
    bsc_timer #(.WIDTH(OVERLOAD_W)) u_overload_timer (
        .clock (clock),
        .rst   (rst),
        .port  (overload_if.timer)
    );

    assign comp_in = '{vcc_above_start, vcc_above_hyst, vcc_above_uvlo,
                       vcc_above_restart, fb_below_ref, fb_below_overload,
                       fb_below_open_loop, current_at_limit, current_above_short,
                       temp_above_trip, temp_cooled};
    assign s = state_reg.sync2;

    // ********************************************************************
    // Helpers
    // ********************************************************************
    function automatic logic [MINOFF_W-1:0] minoff_for(input bsc_stage_type stage);
        logic [MINOFF_W-1:0] value;
        value = MINOFF_W'(`BSC_MINOFF_CYCLES);
        case (stage)
            BSC_STAGE_LONG: value = MINOFF_W'(SOFT_LONG_CYCLES);
            BSC_STAGE_MID:  value = MINOFF_W'(`BSC_SOFT_MID_CYCLES);
            default:        value = MINOFF_W'(`BSC_MINOFF_CYCLES);
        endcase
        return value;
    endfunction

    // Peak limit from the off time just ended, floored at the minimum peak current
    function automatic logic [7:0] peak_for(input logic [7:0] off_us);
        logic [8:0] excess;
        logic [8:0] limit;
        excess = 9'h000;
        if (off_us > 8'(`BSC_MINOFF_US)) begin
            excess = 9'(off_us - 8'(`BSC_MINOFF_US)) * 9'(`BSC_PEAK_SLOPE_MA_US);
        end
        limit = 9'(`BSC_PEAK_MAX_MA) - excess;
        if (excess > 9'(`BSC_PEAK_MAX_MA) || limit < 9'(`BSC_PEAK_MIN_MA)) begin
            limit = 9'(`BSC_PEAK_MIN_MA);
        end
        return limit[7:0];
    endfunction

    // ********************************************************************
    // Next state
    // ********************************************************************
    logic       open_loop_armed;
    logic [8:0] trim_step;
    logic [4:0] trim_sum;

    always_comb begin
        state_next = state_reg;
        state_next.sync1 = comp_in; // R18
        state_next.sync2 = state_reg.sync1; // R18
        trim_step = 9'h000;
        trim_sum = 5'h00;
        leb_if.load = 1'b0;
        leb_if.value = LEB_W'(`BSC_LEB_CYCLES);
        minoff_if.load = 1'b0;
        minoff_if.value = minoff_for(state_reg.stage);
        // Overload delay restarts whenever feedback is back above its level
        overload_if.load = !(state_reg.state == BSC_RUN && s.fb_below_overload); // R13
        overload_if.value = OVERLOAD_W'(OVERLOAD_CYCLES);
        open_loop_armed = (state_reg.stage != BSC_STAGE_LONG)
                       || (state_reg.switch_count >= 7'(`BSC_OPEN_BLANK_SWITCHES)); // R15

        // Microsecond time base for the off-time measurement
        if (state_reg.prescale == 7'(`BSC_CYCLES_PER_US - 1)) begin
            state_next.prescale = '0;
            if (!state_reg.gate && state_reg.off_us != `BSC_OFF_US_MAX) begin
                state_next.off_us = state_reg.off_us + 1'b1;
            end
        end else begin
            state_next.prescale = state_reg.prescale + 1'b1;
        end

        case (state_reg.state)
            BSC_CHARGE: begin
                state_next.gate = 1'b0;
                state_next.hv = 1'b1;
                if (s.vcc_above_start) begin
                    state_next.state = BSC_RUN; // R1
                    state_next.hv = 1'b0; // R1
                    state_next.stage = BSC_STAGE_LONG;
                    state_next.switch_count = '0;
                    state_next.overload_trip = 1'b0;
                    state_next.open_loop_trip = 1'b0;
                end
            end
            BSC_RUN: begin
                if (s.vcc_above_start) begin
                    state_next.hv = 1'b0;
                end else if (!s.vcc_above_hyst) begin
                    state_next.hv = 1'b1; // R2
                end
                if (!s.vcc_above_uvlo) begin
                    state_next.state = BSC_CHARGE; // R3
                    state_next.gate = 1'b0;
                    state_next.hv = 1'b1; // R3
                end else if (s.temp_above_trip) begin
                    state_next.state = BSC_THERMAL; // R16
                    state_next.gate = 1'b0; // R18
                end else if (s.current_above_short) begin
                    state_next.state = BSC_SHORT; // R12
                    state_next.gate = 1'b0; // R18
                end else if (s.fb_below_open_loop && open_loop_armed) begin
                    state_next.state = BSC_RESTART; // R14
                    state_next.gate = 1'b0; // R14
                    state_next.hv = 1'b0;
                    state_next.open_loop_trip = 1'b1;
                end else if (!overload_if.load && overload_if.expired) begin
                    state_next.state = BSC_RESTART; // R13
                    state_next.gate = 1'b0; // R18
                    state_next.hv = 1'b0;
                    state_next.overload_trip = 1'b1;
                end else if (state_reg.gate) begin
                    // Blanking hides the turn-on spike from the limit comparator
                    if (leb_if.expired && s.current_at_limit) begin // R11
                        state_next.gate = 1'b0; // R5
                        state_next.off_us = '0;
                        state_next.prescale = '0;
                        minoff_if.load = 1'b1; // R7
                    end
                end else if (s.fb_below_ref && minoff_if.expired) begin // R7
                    state_next.gate = 1'b1; // R4
                    leb_if.load = 1'b1; // R11
                    state_next.peak_limit = peak_for(state_reg.off_us); // R6
                    state_next.last_off_us = state_reg.off_us;
                    // Shorter off time means more load: pull the reference lower
                    if (state_reg.off_us < state_reg.last_off_us) begin
                        trim_step = 9'(state_reg.last_off_us - state_reg.off_us);
                        trim_step = (trim_step >> 2) + 9'h001; // R10
                        if (trim_step > 9'(`BSC_TRIM_MAX)) begin
                            trim_step = 9'(`BSC_TRIM_MAX);
                        end
                        trim_sum = 5'(state_reg.trim) + 5'(trim_step);
                        state_next.trim = (trim_sum > 5'(`BSC_TRIM_MAX))
                                        ? `BSC_TRIM_MAX : trim_sum[3:0]; // R10
                    end else if (state_reg.off_us > state_reg.last_off_us
                                 && state_reg.trim != '0) begin
                        state_next.trim = state_reg.trim - 1'b1; // R10
                    end
                    if (state_reg.stage != BSC_STAGE_NORMAL) begin
                        if (state_reg.switch_count == 7'(`BSC_STAGE_SWITCHES - 1)) begin
                            state_next.switch_count = '0; // R8
                            state_next.stage = (state_reg.stage == BSC_STAGE_LONG)
                                             ? BSC_STAGE_MID : BSC_STAGE_NORMAL; // R8
                        end else begin
                            state_next.switch_count = state_reg.switch_count + 1'b1;
                        end
                    end
                end else if (!s.fb_below_ref && state_reg.stage != BSC_STAGE_NORMAL
                             && state_reg.switch_count != '0) begin
                    // Feedback back above reference: output has reached its level
                    state_next.stage = BSC_STAGE_NORMAL; // R9
                end
            end
            BSC_SHORT: begin
                state_next.gate = 1'b0; // R18
                if (s.vcc_above_start) begin
                    state_next.hv = 1'b0;
                end else if (!s.vcc_above_hyst) begin
                    state_next.hv = 1'b1;
                end
                if (!s.vcc_above_uvlo) begin
                    state_next.state = BSC_CHARGE;
                    state_next.hv = 1'b1;
                end else if (!s.current_above_short) begin
                    state_next.state = BSC_RUN; // R12
                    state_next.stage = BSC_STAGE_LONG;
                    state_next.switch_count = '0;
                end
            end
            BSC_RESTART: begin
                // Rail is left to sag below the operating level, then recharged
                state_next.gate = 1'b0; // R18
                state_next.hv = 1'b0;
                if (!s.vcc_above_uvlo) begin
                    state_next.state = BSC_CHARGE; // R14
                    state_next.hv = 1'b1;
                end
            end
            BSC_THERMAL: begin
                state_next.gate = 1'b0; // R16
                if (state_reg.hv && s.vcc_above_start) begin
                    state_next.hv = 1'b0; // R17
                end else if (!state_reg.hv && !s.vcc_above_restart) begin
                    state_next.hv = 1'b1; // R17
                end
                if (s.temp_cooled && !s.temp_above_trip) begin
                    state_next.state = BSC_CHARGE; // R16
                    state_next.hv = 1'b1;
                end
            end
            default: begin
                state_next = RESET_STATE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign gate_drive                   = state_reg.gate;
    assign hv_regulator_enable          = state_reg.hv;
    assign peak_limit_ma                = state_reg.peak_limit;
    assign error_amplifier_compensation = state_reg.trim;
    assign running                      = (state_reg.state == BSC_RUN);
    assign short_circuit_protection     = (state_reg.state == BSC_SHORT);
    assign overload_protection          = (state_reg.state == BSC_RESTART)
                                        && state_reg.overload_trip;
    assign open_loop_protection         = (state_reg.state == BSC_RESTART)
                                        && state_reg.open_loop_trip;
    assign thermal_shutdown             = (state_reg.state == BSC_THERMAL);
endmodule

// ---- rtl/bsc_params.svh ----
// Timing, threshold and reset constants of the buck switch controller.
// Assumes a 100 MHz clock; every cycle count is derived from the printed time.
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

`define BSC_CLOCK_MHZ          100
`define BSC_CYCLES_PER_US      (`BSC_CLOCK_MHZ)
`define BSC_LEB_NS             350
// Least time: rounded up to whole cycles
`define BSC_LEB_CYCLES         ((`BSC_LEB_NS * `BSC_CLOCK_MHZ + 999) / 1000)
`define BSC_MINOFF_US          14
`define BSC_SOFT_MID_US        28
`define BSC_SOFT_LONG_US       56
`define BSC_MINOFF_CYCLES      (`BSC_MINOFF_US * `BSC_CYCLES_PER_US)
`define BSC_SOFT_MID_CYCLES    (`BSC_SOFT_MID_US * `BSC_CYCLES_PER_US)
`define BSC_SOFT_LONG_CYCLES   (`BSC_SOFT_LONG_US * `BSC_CYCLES_PER_US)
`define BSC_OVERLOAD_MS        170
`define BSC_OVERLOAD_CYCLES    (`BSC_OVERLOAD_MS * 1000 * `BSC_CYCLES_PER_US)
`define BSC_STAGE_SWITCHES     128
`define BSC_OPEN_BLANK_SWITCHES 64
`define BSC_PEAK_MAX_MA        8'hdc
`define BSC_PEAK_MIN_MA        8'h46
`define BSC_PEAK_SLOPE_MA_US   1
`define BSC_OFF_US_MAX         8'hff
`define BSC_TRIM_MAX           4'hf

`endif

// ---- rtl/bsc_pkg.sv ----
// Types of the buck switch controller; its timers use none of them.
// Constants live in bsc_params.svh; this package holds only types.
package bsc_pkg;

    typedef enum logic [2:0] {
        BSC_CHARGE,
        BSC_RUN,
        BSC_SHORT,
        BSC_RESTART,
        BSC_THERMAL
    } bsc_state_type;

    typedef enum logic [1:0] {
        BSC_STAGE_LONG,
        BSC_STAGE_MID,
        BSC_STAGE_NORMAL
    } bsc_stage_type;

    typedef struct packed {
        logic vcc_above_start;
        logic vcc_above_hyst;
        logic vcc_above_uvlo;
        logic vcc_above_restart;
        logic fb_below_ref;
        logic fb_below_overload;
        logic fb_below_open_loop;
        logic current_at_limit;
        logic current_above_short;
        logic temp_above_trip;
        logic temp_cooled;
    } bsc_comp_type;

endpackage

// ---- rtl/bsc_timer_if.sv ----
// Load/expire handshake between the controller and one down-counting timer.
// The controller owns load and value; the timer reports expiry.
`timescale 1ns/1ns
interface bsc_timer_if #(parameter int WIDTH = 8);
    logic             load;
    logic [WIDTH-1:0] value;
    logic             expired;
    modport owner (output load, output value, input expired);
    modport timer (input load, input value, output expired);
endinterface

// ---- rtl/bsc_timer.sv ----
// One down-counting interval timer for the buck switch controller.
// Load reloads the count on every cycle it is high; expired is high while the count is zero.
`timescale 1ns/1ns
module bsc_timer #(
    parameter int WIDTH = 8
) (
    input  wire logic  clock,
    input  wire logic  rst,
    bsc_timer_if.timer port
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } bsc_timer_state_type;

    bsc_timer_state_type state_reg;
    bsc_timer_state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (port.load) begin
            state_next.count = port.value;
        end else if (state_reg.count != '0) begin
            state_next.count = state_reg.count - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign port.expired = (state_reg.count == '0);
endmodule

// ---- tb/bsc_controller_sva.sv ----
// Checker of the buck switch controller's top ports.
// Assumes one clock domain; bound into every bsc_controller.
`timescale 1ns/1ns
module bsc_controller_sva #(
    parameter int SOFT_LONG_CYCLES = 5600
) (
    input logic clock,
    input logic rst,
    input logic vcc_above_start,
    input logic vcc_above_hyst,
    input logic vcc_above_uvlo,
    input logic vcc_above_restart,
    input logic current_above_short,
    input logic temp_above_trip,
    input logic gate_drive,
    input logic hv_regulator_enable,
    input logic running,
    input logic short_circuit_protection,
    input logic overload_protection,
    input logic open_loop_protection,
    input logic thermal_shutdown
);
    // ****
    // Helper counters
    // ****
    // Shortest minimum off time of any stage
    localparam int OFF_FLOOR = (SOFT_LONG_CYCLES < 1400) ? SOFT_LONG_CYCLES : 1400;
    logic [15:0] on_reg;
    logic [15:0] off_reg;
    logic        fault;
    assign fault = short_circuit_protection | overload_protection | open_loop_protection
                 | thermal_shutdown;
    always_ff @(posedge clock) begin
        on_reg <= gate_drive ? on_reg + 16'h0001 : 16'h0000;
        // Saturated while stopped: a run's first turn-on is not judged
        if (rst || !running) begin
            off_reg <= 16'hffff;
        end else if (gate_drive) begin
            off_reg <= 16'h0000;
        end else if (off_reg != 16'hffff) begin
            off_reg <= off_reg + 16'h0001;
        end
    end
    // ****
    // Assertions
    // ****
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence hot_run_s;
        running && temp_above_trip && vcc_above_uvlo;
    endsequence
    sequence hot_hold_s;
        (temp_above_trip && vcc_above_uvlo) [*4];
    endsequence
    prot_gate_a: assert property (fault |-> !gate_drive)
        else $error("gate on in fault");
    charge_hv_a: assert property (!running && !fault |-> hv_regulator_enable)
        else $error("hv off while charging");
    start_hv_a: assert property ((running && vcc_above_start) [*5] |-> !hv_regulator_enable)
        else $error("hv on above start");
    hyst_hv_a: assert property ((running && !vcc_above_hyst) [*4] |-> hv_regulator_enable)
        else $error("hv off below hyst");
    blank_time_a: assert property ($fell(gate_drive) && running |-> on_reg >= 16'h0023)
        else $error("gate off in blanking");
    min_off_a: assert property ($rose(gate_drive) |-> off_reg >= OFF_FLOOR)
        else $error("off time too short");
    short_stop_a: assert property (current_above_short [*5] |-> !running && !gate_drive)
        else $error("no short stop");
    thermal_stop_a: assert property (hot_run_s ##1 hot_hold_s |-> thermal_shutdown)
        else $error("thermal stop missed");
    thermal_hv_a: assert property ((thermal_shutdown && !vcc_above_restart) [*5]
        |-> hv_regulator_enable)
        else $error("no restart recharge");
endmodule

bind bsc_controller bsc_controller_sva #(.SOFT_LONG_CYCLES(SOFT_LONG_CYCLES)) sva_i (.*);

// ---- tb/bsc_plant.sv ----
// Behavioural plant: supply capacitor, inductor current ramp, feedback divider.
// Assumes the controller's gate and regulator pins act on levels.
`timescale 1ns/1ns
module bsc_plant (
    input  logic      clock,
    input  logic      gate_drive,
    input  logic      hv_regulator_enable,
    input  var  int   fb_hold,
    output logic      vcc_above_start,
    output logic      vcc_above_hyst,
    output logic      vcc_above_uvlo,
    output logic      vcc_above_restart,
    output logic      fb_below_ref,
    output logic      current_at_limit
);
    // Limit comes well inside blanking, so an early limit is shown
    int vcc_mv = 0;
    int on_cnt = 0;
    int off_cnt = 0;
    always @(posedge clock) begin
        if (hv_regulator_enable === 1'b1) vcc_mv <= (vcc_mv > 5990) ? 6000 : vcc_mv + 10;
        else if (vcc_mv > 0) vcc_mv <= vcc_mv - 1;
        on_cnt <= (gate_drive === 1'b1) ? on_cnt + 1 : 0;
        off_cnt <= (gate_drive === 1'b1) ? 0 : off_cnt + 1;
    end
    always_comb begin
        vcc_above_start = vcc_mv >= 5600;
        vcc_above_hyst = vcc_mv >= 5300;
        vcc_above_uvlo = vcc_mv >= 3400;
        vcc_above_restart = vcc_mv >= 2400;
        fb_below_ref = off_cnt >= fb_hold;
        current_at_limit = on_cnt >= 10;
    end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench: controller plus plant model.
// The long soft-start count and the overload count are shortened at the instance.
`timescale 1ns/1ns
module tb;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       fb_below_overload = 1'b0;
    logic       fb_below_open_loop = 1'b0;
    logic       current_above_short = 1'b0;
    logic       temp_above_trip = 1'b0;
    logic       temp_cooled = 1'b0;
    logic       vcc_above_start, vcc_above_hyst, vcc_above_uvlo, vcc_above_restart;
    logic       fb_below_ref, current_at_limit, gate_drive, hv_regulator_enable, running;
    logic       short_circuit_protection, overload_protection;
    logic       open_loop_protection, thermal_shutdown;
    logic [7:0] peak_limit_ma;
    logic [7:0] pk;
    logic [3:0] error_amplifier_compensation;
    int         fb_hold = 0;
    int         num_errors = 0;
    int         num_checks = 0;
    int         off_c, on_c;

    always #5 clock = ~clock;

    bsc_controller #(.SOFT_LONG_CYCLES(200), .OVERLOAD_CYCLES(500)) bsc_controller_i (.*);
    bsc_plant bsc_plant_i (.*);

    // ****
    // Shared tasks
    // ****
    task report_and_stop;
        $display("Checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            num_errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task hang;
        num_errors++;
        $display("ERROR %0t wait limit", $time);
        report_and_stop();
    endtask
    task automatic wait_for(ref logic sig, input logic val, input int lim);
        int n = 0;
        while (sig !== val) begin
            @(negedge clock);
            n++;
            if (n > lim) hang();
        end
    endtask
    // Call just after a turn-off: off_c is then the whole gap
    task pulse;
        off_c = 0;
        on_c = 0;
        while (gate_drive !== 1'b1) begin
            @(negedge clock);
            off_c++;
            if (off_c > 30000) hang();
        end
        pk = peak_limit_ma;
        while (gate_drive === 1'b1) begin
            @(negedge clock);
            on_c++;
            if (on_c > 100) hang();
        end
    endtask

    // ****
    // Scenarios
    // ****
    task soft_start_test;
        wait_for(running, 1'b1, 2000);
        pulse();
        fb_below_open_loop = 1'b1;
        for (int i = 2; i <= 128; i++) begin
            pulse();
            if (i == 50) fb_below_open_loop = 1'b0;
            chk(off_c >= 200 && off_c <= 206, "long off");
        end
        chk(open_loop_protection === 1'b0 && running === 1'b1, "open loop early");
        pulse();
        chk(off_c >= 2800 && off_c <= 2806, "mid off");
        chk(pk >= 8'hcd && pk <= 8'hce, "mid peak");
        fb_below_open_loop = 1'b1;
        wait_for(open_loop_protection, 1'b1, 10);
        chk(gate_drive === 1'b0 && hv_regulator_enable === 1'b0, "open loop stop");
        fb_below_open_loop = 1'b0;
        wait_for(running, 1'b1, 5000);
    endtask
    task load_test;
        logic [3:0] t0;
        pulse();
        chk(on_c >= 35 && on_c <= 38, "on time");
        fb_hold = 3000;
        pulse();
        chk(off_c >= 3000 && off_c <= 3006, "fb off");
        chk(pk >= 8'hcb && pk <= 8'hcc, "long peak");
        t0 = error_amplifier_compensation;
        fb_hold = 1000;
        pulse();
        chk(off_c >= 1400 && off_c <= 1406, "normal off");
        chk(pk === 8'hdc, "full peak");
        chk(error_amplifier_compensation > t0, "trim up");
        t0 = error_amplifier_compensation;
        fb_hold = 20000;
        pulse();
        chk(pk === 8'h46, "peak floor");
        chk(error_amplifier_compensation === t0 - 4'h1, "trim down");
        fb_hold = 1000;
        pulse();
    endtask
    task overload_test;
        fb_below_overload = 1'b1;
        repeat (400) @(negedge clock);
        fb_below_overload = 1'b0;
        repeat (2) @(negedge clock);
        fb_below_overload = 1'b1;
        repeat (450) @(negedge clock);
        chk(overload_protection === 1'b0, "overload early");
        wait_for(overload_protection, 1'b1, 60);
        chk(gate_drive === 1'b0, "overload gate on");
        fb_below_overload = 1'b0;
        wait_for(running, 1'b1, 5000);
    endtask
    task short_test;
        current_above_short = 1'b1;
        repeat (6) @(negedge clock);
        chk(short_circuit_protection === 1'b1 && gate_drive === 1'b0, "no short stop");
        current_above_short = 1'b0;
        wait_for(running, 1'b1, 10);
    endtask
    task thermal_test;
        temp_above_trip = 1'b1;
        repeat (6) @(negedge clock);
        chk(thermal_shutdown === 1'b1 && gate_drive === 1'b0, "no thermal stop");
        wait_for(hv_regulator_enable, 1'b0, 400);
        wait_for(hv_regulator_enable, 1'b1, 5000);
        chk(bsc_plant_i.vcc_mv <= 2400, "late recharge");
        temp_above_trip = 1'b0;
        repeat (100) @(negedge clock);
        chk(running === 1'b0, "early resume");
        temp_cooled = 1'b1;
        wait_for(running, 1'b1, 2000);
        chk(thermal_shutdown === 1'b0, "thermal kept");
    endtask

    initial begin
        repeat (10) @(negedge clock);
        rst = 1'b0;
        soft_start_test();
        load_test();
        overload_test();
        short_test();
        thermal_test();
        report_and_stop();
    end
endmodule
